// file: apm_pkg.sv
package apm_pkg;

    // register indices on the byte-wide register port
    localparam logic [4:0] APM_REG_ACC     = 5'h00;
    localparam logic [4:0] APM_REG_ACC_EXT = 5'h01;
    localparam logic [4:0] APM_REG_B       = 5'h02;
    localparam logic [4:0] APM_REG_B_EXT   = 5'h03;
    localparam logic [4:0] APM_REG_PZ_LO   = 5'h04;
    localparam logic [4:0] APM_REG_PZ_HI   = 5'h05;
    localparam logic [4:0] APM_REG_PO_LO   = 5'h06;
    localparam logic [4:0] APM_REG_PO_HI   = 5'h07;
    localparam logic [4:0] APM_REG_CTRL    = 5'h08;
    localparam logic [4:0] APM_REG_STATUS  = 5'h09;
    localparam logic [4:0] APM_REG_IMM_HI  = 5'h0A;
    localparam logic [4:0] APM_REG_IMM_LO  = 5'h0B;
    localparam logic [4:0] APM_REG_CMD     = 5'h0C;
    localparam logic [4:0] APM_REG_PC_LO   = 5'h0D;
    localparam logic [4:0] APM_REG_PC_HI   = 5'h0E;
    localparam logic [4:0] APM_REG_M0      = 5'h10;
    localparam logic [4:0] APM_REG_M4      = 5'h14;

    // control register fields
    localparam int APM_CTRL_SEL   = 0;
    localparam int APM_CTRL_DBG   = 1;
    localparam int APM_CTRL_FLASH = 2;

    // status register fields
    localparam int APM_ST_CY   = 0;
    localparam int APM_ST_OV   = 1;
    localparam int APM_ST_BUSY = 2;
    localparam int APM_ST_ILL  = 3;

    // reset values
    localparam logic [7:0]  APM_RST_BYTE = 8'h00;
    localparam logic [15:0] APM_RST_WORD = 16'h0000;
    localparam logic [39:0] APM_RST_M    = 40'h00_0000_0000;

    // extension prefix and the instruction bytes following it
    localparam logic [7:0] APM_PREFIX   = 8'hA5;
    localparam logic [7:0] APM_OP_MAC   = 8'hA4;
    localparam logic [7:0] APM_OP_LDP   = 8'h90;
    localparam logic [7:0] APM_OP_RD    = 8'hE0;
    localparam logic [7:0] APM_OP_WR    = 8'hF0;
    localparam logic [7:0] APM_OP_BRK   = 8'h00;

    // cycle counts per instruction
    localparam logic [3:0] APM_CYC_MAC  = 4'h9;
    localparam logic [3:0] APM_CYC_LDP  = 4'h4;
    localparam logic [3:0] APM_CYC_RAM  = 4'h3;
    localparam logic [3:0] APM_CYC_SLOW = 4'h5;
    localparam logic [3:0] APM_CYC_BRK  = 4'h2;

    // program counter advance per instruction, prefix included
    localparam logic [15:0] APM_LEN_2 = 16'h0002;
    localparam logic [15:0] APM_LEN_4 = 16'h0004;

    // data space codes on the memory port
    localparam logic [1:0] APM_SP_ERAM  = 2'h0;
    localparam logic [1:0] APM_SP_FLASH = 2'h1;
    localparam logic [1:0] APM_SP_EXT   = 2'h2;

    typedef enum logic [0:0] {
        APM_IDLE = 1'b0,
        APM_RUN  = 1'b1
    } apm_state_e;

    typedef enum logic [2:0] {
        APM_X_NONE = 3'h0,
        APM_X_MAC  = 3'h1,
        APM_X_LDP  = 3'h2,
        APM_X_RD   = 3'h3,
        APM_X_WR   = 3'h4,
        APM_X_BRK  = 3'h5
    } apm_op_e;

endpackage

// file: apm_mac_if.sv
`timescale 1ns/1ps
interface apm_mac_if;
    logic [15:0] op_a;
    logic [15:0] op_b;
    logic [39:0] m;
    logic [39:0] sum;
    logic        ovf;

    modport core (output op_a, output op_b, output m,
                  input sum, input ovf);
    modport unit (input op_a, input op_b, input m,
                  output sum, output ovf);
endinterface // apm_mac_if

// file: apm_mac.sv
`timescale 1ns/1ps
module apm_mac (
    apm_mac_if.unit mac
);
    logic signed [31:0] prod;
    logic        [39:0] prod_x;

    // both operands widened to the product width so no bits are lost
    assign prod   = 32'(signed'(mac.op_a))
                  * 32'(signed'(mac.op_b));
    assign prod_x = {{8{prod[31]}}, prod};
    // plain 40-bit add, carry out dropped on purpose
    assign mac.sum = mac.m + prod_x;
    // same-sign addends giving a result of the other sign
    assign mac.ovf = (mac.m[39] == prod_x[39])
                  && (mac.sum[39] != mac.m[39]);
endmodule // apm_mac

// file: apm_exec.sv
`timescale 1ns/1ps
module apm_exec #(
    parameter int unsigned ERAM_BYTES = 1152
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic [4:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [7:0]  o_reg_rdata,
    output logic      [15:0] o_mem_addr,
    output logic      [1:0]  o_mem_space,
    output logic             o_mem_rd,
    output logic             o_mem_wr,
    output logic      [7:0]  o_mem_wdata,
    input  wire logic [7:0]  i_mem_rdata,
    output logic             o_busy,
    output logic             o_debug_break
);

    apm_mac_if mac_if ();

    apm_mac u_mac (
        .mac (mac_if.unit)
    );

    apm_pkg::apm_state_e state_q;
    apm_pkg::apm_op_e    op_q;
    apm_pkg::apm_op_e    op_new;
    logic [3:0]  cnt_q;
    logic [3:0]  cyc_new;
    logic [7:0]  acc_q;
    logic [7:0]  acc_ext_q;
    logic [7:0]  b_q;
    logic [7:0]  b_ext_q;
    logic [15:0] pz_q;
    logic [15:0] po_q;
    logic [15:0] imm_q;
    logic [15:0] pc_q;
    logic [39:0] m_q;
    logic        sel_q;
    logic        dbg_q;
    logic        flash_q;
    logic        cy_q;
    logic        ov_q;
    logic        ill_q;
    logic        prefix_q;
    logic [7:0]  rdata_q;
    logic [7:0]  rd_mux;
    logic [15:0] mem_addr_q;
    logic [1:0]  mem_space_q;
    logic        mem_rd_q;
    logic        mem_wr_q;
    logic [7:0]  mem_wdata_q;
    logic        brk_q;

    // register port decode; writes are refused while an instruction runs
    wire busy    = (state_q == apm_pkg::APM_RUN);
    wire wr_ok   = i_reg_wr & ~busy;
    wire we_acc  = wr_ok & (i_reg_addr == apm_pkg::APM_REG_ACC);
    wire we_acx  = wr_ok & (i_reg_addr == apm_pkg::APM_REG_ACC_EXT);
    wire we_b    = wr_ok & (i_reg_addr == apm_pkg::APM_REG_B);
    wire we_bx   = wr_ok & (i_reg_addr == apm_pkg::APM_REG_B_EXT);
    wire we_pzl  = wr_ok & (i_reg_addr == apm_pkg::APM_REG_PZ_LO);
    wire we_pzh  = wr_ok & (i_reg_addr == apm_pkg::APM_REG_PZ_HI);
    wire we_pol  = wr_ok & (i_reg_addr == apm_pkg::APM_REG_PO_LO);
    wire we_poh  = wr_ok & (i_reg_addr == apm_pkg::APM_REG_PO_HI);
    wire we_ctrl = wr_ok & (i_reg_addr == apm_pkg::APM_REG_CTRL);
    wire we_st   = wr_ok & (i_reg_addr == apm_pkg::APM_REG_STATUS);
    wire we_imh  = wr_ok & (i_reg_addr == apm_pkg::APM_REG_IMM_HI);
    wire we_iml  = wr_ok & (i_reg_addr == apm_pkg::APM_REG_IMM_LO);
    wire we_cmd  = wr_ok & (i_reg_addr == apm_pkg::APM_REG_CMD);
    wire we_pcl  = wr_ok & (i_reg_addr == apm_pkg::APM_REG_PC_LO);
    wire we_pch  = wr_ok & (i_reg_addr == apm_pkg::APM_REG_PC_HI);
    wire we_m    = wr_ok & (i_reg_addr >= apm_pkg::APM_REG_M0)
                         & (i_reg_addr <= apm_pkg::APM_REG_M4);
    wire [2:0] m_idx = 3'(i_reg_addr - apm_pkg::APM_REG_M0);

    // alternate pointer and its data space
    wire [15:0] alt_ptr = sel_q ? pz_q : po_q;
    wire        in_eram = alt_ptr < 16'(ERAM_BYTES);
    wire [1:0]  space   = in_eram ? apm_pkg::APM_SP_ERAM
                        : flash_q ? apm_pkg::APM_SP_FLASH
                        : apm_pkg::APM_SP_EXT;
    wire [3:0]  cyc_mem = in_eram ? apm_pkg::APM_CYC_RAM
                                  : apm_pkg::APM_CYC_SLOW;

    // instruction decode; an opcode is only taken after the prefix byte
    wire is_pre  = we_cmd & ~prefix_q
                 & (i_reg_wdata == apm_pkg::APM_PREFIX);
    wire known   = (op_new != apm_pkg::APM_X_NONE);
    wire start   = we_cmd & prefix_q & known;
    wire bad_cmd = we_cmd & ~is_pre & ~start;

    assign op_new =
        (i_reg_wdata == apm_pkg::APM_OP_MAC) ? apm_pkg::APM_X_MAC :
        (i_reg_wdata == apm_pkg::APM_OP_LDP) ? apm_pkg::APM_X_LDP :
        (i_reg_wdata == apm_pkg::APM_OP_RD)  ? apm_pkg::APM_X_RD  :
        (i_reg_wdata == apm_pkg::APM_OP_WR)  ? apm_pkg::APM_X_WR  :
        (i_reg_wdata == apm_pkg::APM_OP_BRK) ? apm_pkg::APM_X_BRK :
                                               apm_pkg::APM_X_NONE;

    assign cyc_new =
        (op_new == apm_pkg::APM_X_MAC) ? apm_pkg::APM_CYC_MAC :
        (op_new == apm_pkg::APM_X_LDP) ? apm_pkg::APM_CYC_LDP :
        (op_new == apm_pkg::APM_X_BRK) ? apm_pkg::APM_CYC_BRK :
                                         cyc_mem;

    // the last cycle of an instruction commits all of its effects
    wire commit = busy & (cnt_q == 4'h1);
    wire c_mac  = commit & (op_q == apm_pkg::APM_X_MAC);
    wire c_ldp  = commit & (op_q == apm_pkg::APM_X_LDP);
    wire c_rd   = commit & (op_q == apm_pkg::APM_X_RD);
    wire c_brk  = commit & (op_q == apm_pkg::APM_X_BRK);
    wire brk_hit = c_brk & dbg_q;
    wire [15:0] pc_len = (op_q == apm_pkg::APM_X_LDP) ? apm_pkg::APM_LEN_4
                                                      : apm_pkg::APM_LEN_2;

    // operand bytes are only read by the multiplier, never written back
    assign mac_if.op_a = {acc_ext_q, acc_q};
    assign mac_if.op_b = {b_ext_q, b_q};
    assign mac_if.m    = m_q;

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q <= apm_pkg::APM_IDLE;
            op_q    <= apm_pkg::APM_X_NONE;
            cnt_q   <= 4'h0;
        end
        else if (start)
        begin
            state_q <= apm_pkg::APM_RUN;
            op_q    <= op_new;
            cnt_q   <= cyc_new;
        end
        else if (commit)
        begin
            state_q <= apm_pkg::APM_IDLE;
            op_q    <= apm_pkg::APM_X_NONE;
            cnt_q   <= 4'h0;
        end
        else if (busy)
        begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            prefix_q <= 1'b0;
        end
        else if (we_cmd)
        begin
            prefix_q <= is_pre;
        end
    end

    // operand bytes: the accumulator byte also takes read data
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            acc_q     <= apm_pkg::APM_RST_BYTE;
            acc_ext_q <= apm_pkg::APM_RST_BYTE;
            b_q       <= apm_pkg::APM_RST_BYTE;
            b_ext_q   <= apm_pkg::APM_RST_BYTE;
        end
        else
        begin
            if (c_rd)
                acc_q <= i_mem_rdata;
            else if (we_acc)
                acc_q <= i_reg_wdata;
            if (we_acx)
                acc_ext_q <= i_reg_wdata;
            if (we_b)
                b_q <= i_reg_wdata;
            if (we_bx)
                b_ext_q <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pz_q <= apm_pkg::APM_RST_WORD;
            po_q <= apm_pkg::APM_RST_WORD;
        end
        else
        begin
            if (c_ldp & sel_q)
                pz_q <= imm_q;
            else if (we_pzl)
                pz_q[7:0] <= i_reg_wdata;
            else if (we_pzh)
                pz_q[15:8] <= i_reg_wdata;
            if (c_ldp & ~sel_q)
                po_q <= imm_q;
            else if (we_pol)
                po_q[7:0] <= i_reg_wdata;
            else if (we_poh)
                po_q[15:8] <= i_reg_wdata;
        end
    end

    // immediate bytes three and four of the pointer load
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            imm_q <= apm_pkg::APM_RST_WORD;
        else if (we_imh)
            imm_q[15:8] <= i_reg_wdata;
        else if (we_iml)
            imm_q[7:0] <= i_reg_wdata;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sel_q   <= 1'b0;
            dbg_q   <= 1'b0;
            flash_q <= 1'b0;
        end
        else if (we_ctrl)
        begin
            sel_q   <= i_reg_wdata[apm_pkg::APM_CTRL_SEL];
            dbg_q   <= i_reg_wdata[apm_pkg::APM_CTRL_DBG];
            flash_q <= i_reg_wdata[apm_pkg::APM_CTRL_FLASH];
        end
    end

    // flags: carry and overflow change only on the accumulate or a status write
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cy_q  <= 1'b0;
            ov_q  <= 1'b0;
            ill_q <= 1'b0;
        end
        else
        begin
            if (c_mac)
            begin
                cy_q <= mac_if.sum[39];
                ov_q <= ov_q | mac_if.ovf;
            end
            else if (we_st)
            begin
                cy_q <= i_reg_wdata[apm_pkg::APM_ST_CY];
                ov_q <= i_reg_wdata[apm_pkg::APM_ST_OV];
            end
            // a new fault wins over a software clear
            if (bad_cmd)
                ill_q <= 1'b1;
            else if (we_st)
                ill_q <= i_reg_wdata[apm_pkg::APM_ST_ILL];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            m_q <= apm_pkg::APM_RST_M;
        else if (c_mac)
            m_q <= mac_if.sum;
        else if (we_m)
            m_q[m_idx*8 +: 8] <= i_reg_wdata;
    end

    // a taken breakpoint holds the counter for the debug unit
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            pc_q <= apm_pkg::APM_RST_WORD;
        else if (commit & ~brk_hit)
            pc_q <= pc_q + pc_len;
        else if (we_pcl)
            pc_q[7:0] <= i_reg_wdata;
        else if (we_pch)
            pc_q[15:8] <= i_reg_wdata;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            brk_q <= 1'b0;
        else
            brk_q <= brk_hit;
    end

    // memory strobes stand for the whole access, address held steady
    wire mem_go = start & ((op_new == apm_pkg::APM_X_RD)
                        | (op_new == apm_pkg::APM_X_WR));

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            mem_addr_q  <= apm_pkg::APM_RST_WORD;
            mem_space_q <= apm_pkg::APM_SP_ERAM;
            mem_rd_q    <= 1'b0;
            mem_wr_q    <= 1'b0;
            mem_wdata_q <= apm_pkg::APM_RST_BYTE;
        end
        else if (mem_go)
        begin
            mem_addr_q  <= alt_ptr;
            mem_space_q <= space;
            mem_rd_q    <= (op_new == apm_pkg::APM_X_RD);
            mem_wr_q    <= (op_new == apm_pkg::APM_X_WR);
            mem_wdata_q <= acc_q;
        end
        else if (commit)
        begin
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
        end
    end

    // register read-back
    always_comb
    begin
        rd_mux = 8'h00;
        unique case (i_reg_addr)
            apm_pkg::APM_REG_ACC:     rd_mux = acc_q;
            apm_pkg::APM_REG_ACC_EXT: rd_mux = acc_ext_q;
            apm_pkg::APM_REG_B:       rd_mux = b_q;
            apm_pkg::APM_REG_B_EXT:   rd_mux = b_ext_q;
            apm_pkg::APM_REG_PZ_LO:   rd_mux = pz_q[7:0];
            apm_pkg::APM_REG_PZ_HI:   rd_mux = pz_q[15:8];
            apm_pkg::APM_REG_PO_LO:   rd_mux = po_q[7:0];
            apm_pkg::APM_REG_PO_HI:   rd_mux = po_q[15:8];
            apm_pkg::APM_REG_CTRL:    rd_mux = {5'h00, flash_q, dbg_q, sel_q};
            apm_pkg::APM_REG_STATUS:  rd_mux = {4'h0, ill_q, busy, ov_q, cy_q};
            apm_pkg::APM_REG_IMM_HI:  rd_mux = imm_q[15:8];
            apm_pkg::APM_REG_IMM_LO:  rd_mux = imm_q[7:0];
            apm_pkg::APM_REG_PC_LO:   rd_mux = pc_q[7:0];
            apm_pkg::APM_REG_PC_HI:   rd_mux = pc_q[15:8];
            default:
            begin
                if (we_m | (i_reg_addr >= apm_pkg::APM_REG_M0
                          && i_reg_addr <= apm_pkg::APM_REG_M4))
                    rd_mux = m_q[m_idx*8 +: 8];
                else
                    rd_mux = 8'h00;
            end
        endcase
    end

    // read data live for one cycle only, zero otherwise
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rdata_q <= 8'h00;
        else
            rdata_q <= i_reg_rd ? rd_mux : 8'h00;
    end

    assign o_reg_rdata   = rdata_q;
    assign o_mem_addr    = mem_addr_q;
    assign o_mem_space   = mem_space_q;
    assign o_mem_rd      = mem_rd_q;
    assign o_mem_wr      = mem_wr_q;
    assign o_mem_wdata   = mem_wdata_q;
    assign o_busy        = busy;
    assign o_debug_break = brk_q;

endmodule // apm_exec

// file: apm_exec_props.sv
`timescale 1ns/1ps
module apm_exec_chk #(
    parameter int unsigned ERAM_BYTES = 1152
) (
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    input wire logic        i_reg_rd,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic [15:0] o_mem_addr,
    input wire logic [1:0]  o_mem_space,
    input wire logic        o_mem_rd,
    input wire logic        o_mem_wr,
    input wire logic [7:0]  o_mem_wdata,
    input wire logic        o_busy,
    input wire logic        o_debug_break
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    chk_acc_in_busy: assert property ((o_mem_rd || o_mem_wr) |-> o_busy)
        else $error("memory access outside busy");
    chk_ram_rd_len: assert property ($rose(o_mem_rd) && o_mem_space == 2'h0
        |-> (o_mem_rd && o_busy)[*3] ##1 (!o_mem_rd && !o_busy))
        else $error("ram read length wrong");
    chk_slow_rd_len: assert property ($rose(o_mem_rd) && o_mem_space != 2'h0
        |-> (o_mem_rd && o_busy)[*5] ##1 !o_busy)
        else $error("slow read length wrong");
    chk_ram_wr_len: assert property ($rose(o_mem_wr) && o_mem_space == 2'h0
        |-> o_mem_wr[*3] ##1 !o_mem_wr)
        else $error("ram write length wrong");
    chk_space_map: assert property ((o_mem_rd || o_mem_wr)
        |-> ((o_mem_addr < ERAM_BYTES) == (o_mem_space == 2'h0)))
        else $error("space does not match address");
    chk_addr_hold: assert property (o_busy && $past(o_busy)
        && (o_mem_rd || o_mem_wr) |-> $stable(o_mem_addr) && $stable(o_mem_space))
        else $error("address moved during access");
    chk_wdata_hold: assert property (o_mem_wr && $past(o_mem_wr)
        |-> $stable(o_mem_wdata))
        else $error("write data moved during access");
    chk_rw_apart: assert property (!(o_mem_rd && o_mem_wr))
        else $error("read and write together");
    chk_brk_pulse: assert property (o_debug_break |=> !o_debug_break)
        else $error("break pulse too long");
    chk_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
        else $error("read data outside its cycle");

    // one cover per main transfer kind, plus one for the break pulse
    cov_ram_rd: cover property ($rose(o_mem_rd) && o_mem_space == 2'h0);
    cov_slow_rd: cover property ($rose(o_mem_rd) && o_mem_space != 2'h0);
    cov_wr: cover property ($rose(o_mem_wr));
    cov_brk: cover property (o_debug_break);
endmodule // apm_exec_chk

bind apm_exec apm_exec_chk #(.ERAM_BYTES(ERAM_BYTES)) u_apm_exec_chk (
    .i_core_clk    (i_core_clk),
    .i_rst_n       (i_rst_n),
    .i_reg_rd      (i_reg_rd),
    .o_reg_rdata   (o_reg_rdata),
    .o_mem_addr    (o_mem_addr),
    .o_mem_space   (o_mem_space),
    .o_mem_rd      (o_mem_rd),
    .o_mem_wr      (o_mem_wr),
    .o_mem_wdata   (o_mem_wdata),
    .o_busy        (o_busy),
    .o_debug_break (o_debug_break)
);

// file: test_apm_exec.sv
`timescale 1ns/1ps
module test_apm_exec;
    localparam int unsigned ERAM = 1152;
    logic        i_core_clk;
    logic        i_rst_n;
    logic [4:0]  i_reg_addr;
    logic [7:0]  i_reg_wdata;
    logic        i_reg_wr;
    logic        i_reg_rd;
    logic [7:0]  o_reg_rdata;
    logic [15:0] o_mem_addr;
    logic [1:0]  o_mem_space;
    logic        o_mem_rd;
    logic        o_mem_wr;
    logic [7:0]  o_mem_wdata;
    logic [7:0]  i_mem_rdata;
    logic        o_busy;
    logic        o_debug_break;
    int          fail_count;
    int          checks_done;
    int          cycles;
    logic        brk_seen;
    logic [15:0] cap_addr;
    logic [1:0]  cap_space;
    logic [1:0]  cap_rw;
    logic [7:0]  cap_wdata;

    apm_exec #(.ERAM_BYTES(ERAM)) u_apm_exec (
        .i_core_clk    (i_core_clk),
        .i_rst_n       (i_rst_n),
        .i_reg_addr    (i_reg_addr),
        .i_reg_wdata   (i_reg_wdata),
        .i_reg_wr      (i_reg_wr),
        .i_reg_rd      (i_reg_rd),
        .o_reg_rdata   (o_reg_rdata),
        .o_mem_addr    (o_mem_addr),
        .o_mem_space   (o_mem_space),
        .o_mem_rd      (o_mem_rd),
        .o_mem_wr      (o_mem_wr),
        .o_mem_wdata   (o_mem_wdata),
        .i_mem_rdata   (i_mem_rdata),
        .o_busy        (o_busy),
        .o_debug_break (o_debug_break)
    );

    initial
    begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end

    // the break pulse lasts one cycle, so it is latched here
    always @(posedge i_core_clk)
    begin
        cycles <= cycles + 1;
        if (o_debug_break === 1'b1)
            brk_seen <= 1'b1;
        if (cycles == 20000)
        begin
            fail_count = fail_count + 1;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_wr    <= 1'b1;
        @(posedge i_core_clk);
        i_reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        i_reg_addr <= a;
        i_reg_rd   <= 1'b1;
        @(posedge i_core_clk);
        i_reg_rd   <= 1'b0;
        @(negedge i_core_clk);
        d = o_reg_rdata;
    endtask

    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        cmp({32'h0000_0000, d}, {32'h0000_0000, e});
    endtask

    // counts busy cycles; port values are captured in the first one
    task automatic issue(input logic [7:0] op, output int n);
        wr(apm_pkg::APM_REG_CMD, apm_pkg::APM_PREFIX);
        wr(apm_pkg::APM_REG_CMD, op);
        n = 0;
        @(negedge i_core_clk);
        cap_addr = o_mem_addr;
        cap_space = o_mem_space;
        cap_rw = {o_mem_rd, o_mem_wr};
        cap_wdata = o_mem_wdata;
        while (o_busy === 1'b1 && n < 20)
        begin
            n = n + 1;
            @(negedge i_core_clk);
        end
    endtask

    task automatic wm(input logic [39:0] m);
        for (int i = 0; i < 5; i++)
            wr(5'(apm_pkg::APM_REG_M0 + i), m[8*i+:8]);
    endtask

    task automatic mac_case(input logic [15:0] a, input logic [15:0] b,
                            input logic [39:0] me, input logic [7:0] st);
        logic [7:0]  d;
        logic [39:0] m;
        int          n;
        wr(apm_pkg::APM_REG_ACC, a[7:0]);
        wr(apm_pkg::APM_REG_ACC_EXT, a[15:8]);
        wr(apm_pkg::APM_REG_B, b[7:0]);
        wr(apm_pkg::APM_REG_B_EXT, b[15:8]);
        issue(apm_pkg::APM_OP_MAC, n);
        cmp(40'(n), 40'(apm_pkg::APM_CYC_MAC));
        for (int i = 0; i < 5; i++)
        begin
            rd(5'(apm_pkg::APM_REG_M0 + i), d);
            m[8*i+:8] = d;
        end
        cmp(m, me);
        rchk(apm_pkg::APM_REG_STATUS, st);
        rchk(apm_pkg::APM_REG_ACC, a[7:0]);
        rchk(apm_pkg::APM_REG_ACC_EXT, a[15:8]);
        rchk(apm_pkg::APM_REG_B, b[7:0]);
        rchk(apm_pkg::APM_REG_B_EXT, b[15:8]);
    endtask

    task automatic test_mac;
        wr(apm_pkg::APM_REG_STATUS, 8'h00);
        wm(40'h0);
        mac_case(16'h0050, 16'h00A0, 40'h3200, 8'h00);
        mac_case(16'h8000, 16'h7FFF, 40'hFF_C000_B200, 8'h01);
        wm(40'h7F_FFFF_FFFF);
        mac_case(16'h0001, 16'h0001, 40'h80_0000_0000, 8'h03);
        wm(40'h0);
        mac_case(16'h0000, 16'h0000, 40'h0, 8'h02);
        $display("test mac done");
    endtask

    task automatic ldp_case(input logic sel, input logic [15:0] imm);
        int n;
        wr(apm_pkg::APM_REG_CTRL, {7'h00, sel});
        wr(apm_pkg::APM_REG_STATUS, 8'h03);
        wr(apm_pkg::APM_REG_PZ_LO, 8'h11);
        wr(apm_pkg::APM_REG_PZ_HI, 8'h22);
        wr(apm_pkg::APM_REG_PO_LO, 8'h33);
        wr(apm_pkg::APM_REG_PO_HI, 8'h44);
        wr(apm_pkg::APM_REG_IMM_HI, imm[15:8]);
        wr(apm_pkg::APM_REG_IMM_LO, imm[7:0]);
        issue(apm_pkg::APM_OP_LDP, n);
        cmp(40'(n), 40'(apm_pkg::APM_CYC_LDP));
        rchk(apm_pkg::APM_REG_PZ_LO, sel ? imm[7:0] : 8'h11);
        rchk(apm_pkg::APM_REG_PZ_HI, sel ? imm[15:8] : 8'h22);
        rchk(apm_pkg::APM_REG_PO_LO, sel ? 8'h33 : imm[7:0]);
        rchk(apm_pkg::APM_REG_PO_HI, sel ? 8'h44 : imm[15:8]);
        rchk(apm_pkg::APM_REG_STATUS, 8'h03);
    endtask

    task automatic test_ldp;
        ldp_case(1'b0, 16'h5678);
        ldp_case(1'b1, 16'hA5C3);
        $display("test ldp done");
    endtask

    task automatic movx_case(input logic sel, input logic flash,
                             input logic wop, input logic [15:0] p);
        int         n;
        logic       ram;
        logic [1:0] sp;
        ram = (p < 16'(ERAM));
        sp = ram ? 2'h0 : (flash ? 2'h1 : 2'h2);
        wr(apm_pkg::APM_REG_CTRL, {5'h00, flash, 1'b0, sel});
        wr(sel ? apm_pkg::APM_REG_PZ_LO : apm_pkg::APM_REG_PO_LO, p[7:0]);
        wr(sel ? apm_pkg::APM_REG_PZ_HI : apm_pkg::APM_REG_PO_HI, p[15:8]);
        wr(sel ? apm_pkg::APM_REG_PO_LO : apm_pkg::APM_REG_PZ_LO, ~p[7:0]);
        wr(sel ? apm_pkg::APM_REG_PO_HI : apm_pkg::APM_REG_PZ_HI, ~p[15:8]);
        wr(apm_pkg::APM_REG_ACC, 8'hC3);
        i_mem_rdata <= 8'h5C;
        issue(wop ? apm_pkg::APM_OP_WR : apm_pkg::APM_OP_RD, n);
        cmp(40'(n), ram ? 40'h3 : 40'h5);
        cmp({24'h00_0000, cap_addr}, {24'h00_0000, p});
        cmp(40'(cap_space), 40'(sp));
        cmp(40'(cap_rw), wop ? 40'h1 : 40'h2);
        if (wop)
            cmp(40'(cap_wdata), 40'hC3);
        rchk(apm_pkg::APM_REG_ACC, wop ? 8'hC3 : 8'h5C);
    endtask

    task automatic test_movx;
        movx_case(1'b0, 1'b0, 1'b0, 16'h047F);
        movx_case(1'b1, 1'b1, 1'b0, 16'h0480);
        movx_case(1'b0, 1'b0, 1'b0, 16'hFFFF);
        movx_case(1'b0, 1'b0, 1'b1, 16'h4567);
        movx_case(1'b1, 1'b0, 1'b1, 16'h0010);
        $display("test movx done");
    endtask

    task automatic test_brk;
        logic [7:0]  lo;
        logic [7:0]  hi;
        logic [15:0] pc;
        int          n;
        wr(apm_pkg::APM_REG_CTRL, 8'h00);
        rd(apm_pkg::APM_REG_PC_LO, lo);
        rd(apm_pkg::APM_REG_PC_HI, hi);
        pc = {hi, lo} + 16'h0002;
        brk_seen = 1'b0;
        issue(apm_pkg::APM_OP_BRK, n);
        cmp(40'(n), 40'(apm_pkg::APM_CYC_BRK));
        rchk(apm_pkg::APM_REG_PC_LO, pc[7:0]);
        rchk(apm_pkg::APM_REG_PC_HI, pc[15:8]);
        cmp(40'(brk_seen), 40'h0);
        wr(apm_pkg::APM_REG_CTRL, 8'h02);
        issue(apm_pkg::APM_OP_BRK, n);
        repeat (3) @(posedge i_core_clk);
        cmp(40'(brk_seen), 40'h1);
        rchk(apm_pkg::APM_REG_PC_LO, pc[7:0]);
        rchk(apm_pkg::APM_REG_PC_HI, pc[15:8]);
        // opcode without its prefix is refused and flagged
        wr(apm_pkg::APM_REG_STATUS, 8'h00);
        wr(apm_pkg::APM_REG_CMD, apm_pkg::APM_OP_MAC);
        rchk(apm_pkg::APM_REG_STATUS, 8'h08);
        rchk(5'h1F, 8'h00);
        $display("test brk done");
    endtask

    initial
    begin
        cycles = 0;
        fail_count = 0;
        checks_done = 0;
        brk_seen = 1'b0;
        i_rst_n = 1'b0;
        i_reg_addr = 5'h00;
        i_reg_wdata = 8'h00;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        i_mem_rdata = 8'h00;
        repeat (16) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        test_mac();
        test_ldp();
        test_movx();
        test_brk();
        wrap_up();
    end
endmodule // test_apm_exec
